// File: verilog/port_stats_pkg.sv
/*
  Constants shared by the per-port frame statistics counter block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package port_stats_pkg;
  localparam int LEN_W = 16;
  localparam int CNT_W = 32;
  localparam int OCT_W = 48;
  localparam logic [LEN_W-1:0] LEN_64 = 16'h0040;
  localparam logic [LEN_W-1:0] LEN_127 = 16'h007f;
  localparam logic [LEN_W-1:0] LEN_255 = 16'h00ff;
  localparam logic [LEN_W-1:0] LEN_511 = 16'h01ff;
  localparam logic [LEN_W-1:0] LEN_1023 = 16'h03ff;
  localparam logic [LEN_W-1:0] LEN_1518 = 16'h05ee;
  localparam logic [LEN_W-1:0] LEN_1522 = 16'h05f2;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [OCT_W-1:0] OCT_RESET = 48'h0000_0000_0000;
  // Length bucket indices.
  localparam int BKT_64 = 0;
  localparam int BKT_127 = 1;
  localparam int BKT_255 = 2;
  localparam int BKT_511 = 3;
  localparam int BKT_1023 = 4;
  localparam int BKT_1518 = 5;
  localparam int BKT_1522 = 6;
  localparam int BKT_OVER = 7;
  localparam int BKT_N = 8;
  typedef enum logic [1:0] {
    ADDR_UNICAST = 2'h0,
    ADDR_MULTICAST = 2'h1,
    ADDR_BROADCAST = 2'h2
  } addr_kind_t;
endpackage : port_stats_pkg

// File: verilog/port_frame_statistics_counters.sv
/*
  Per-port Ethernet frame statistics counters for receive and transmit.
  Assumes the port MAC reports one end-of-frame status pulse per frame
  per direction, synchronous to core_clk_in; counters are read directly.
*/
`timescale 1ns/1ps
// Summary of operation
// - Octet counters add every frame length, FCS included.
// - Count exactly 64-octet frames per direction.
// - Count 65 to 127 octet frames.
// - Count 128 to 255 octet frames.
// - Count 256 to 511 octet frames.
// - Count 512 to 1023 octet frames.
// - Count 1024 to 1518 octet frames.
// - Count 1519 to 1522 octet tagged frames.
// - Count received frames above 1522 octets.
// - Count received frames without any error.
// - Count good received unicast frames delivered upward.
// - Count received multicast frames, broadcast excluded.
// - Count received broadcast frames only.
// - Count received frames with any MAC error.
// - Jabber: over 1518 octets with bad FCS.
// - Count received frames under 64 octets.
// - Alignment: 64-1518, bad FCS, odd bits.
// - FCS error: 64-1518, bad FCS, whole octets.
// - Count PAUSE frames, not in half duplex.
module port_frame_statistics_counters (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic half_duplex_in,
  input wire logic rx_end_in,
  input wire logic [port_stats_pkg::LEN_W-1:0] rx_len_in,
  input wire port_stats_pkg::addr_kind_t rx_addr_kind_in,
  input wire logic rx_fcs_bad_in,
  input wire logic rx_dribble_in,
  input wire logic rx_other_err_in,
  input wire logic rx_pause_in,
  input wire logic tx_end_in,
  input wire logic [port_stats_pkg::LEN_W-1:0] tx_len_in,
  output logic [port_stats_pkg::OCT_W-1:0] rx_octets_out,
  output logic [port_stats_pkg::OCT_W-1:0] tx_octets_out,
  output logic [port_stats_pkg::BKT_N*port_stats_pkg::CNT_W-1:0] rx_bucket_out,
  output logic [port_stats_pkg::BKT_N*port_stats_pkg::CNT_W-1:0] tx_bucket_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_good_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_unicast_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_multicast_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_broadcast_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_mac_err_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_jabber_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_undersize_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_align_err_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_fcs_err_out,
  output logic [port_stats_pkg::CNT_W-1:0] rx_pause_out
);
  import port_stats_pkg::*;

  // One-hot bucket of a length of 64 or more; shorter lengths hit no bucket, lengths above 1522 hit the last bucket.
  function automatic logic [BKT_N-1:0] bucket_of(input logic [LEN_W-1:0] len);
    logic [BKT_N-1:0] b;
    b = '0;
    b[BKT_64] = (len == LEN_64);
    b[BKT_127] = (len > LEN_64) && (len <= LEN_127);
    b[BKT_255] = (len > LEN_127) && (len <= LEN_255);
    b[BKT_511] = (len > LEN_255) && (len <= LEN_511);
    b[BKT_1023] = (len > LEN_511) && (len <= LEN_1023);
    b[BKT_1518] = (len > LEN_1023) && (len <= LEN_1518);
    b[BKT_1522] = (len > LEN_1518) && (len <= LEN_1522);
    b[BKT_OVER] = (len > LEN_1522);
    return b;
  endfunction : bucket_of

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic hit);
    // Plain wrap past all ones keeps the counter free-running.
    return c + {{(CNT_W-1){1'b0}}, hit};
  endfunction : bump

  // Classification is decided from the end-of-frame status alone.
  wire logic rx_ev = clk_en_in && rx_end_in;
  wire logic tx_ev = clk_en_in && tx_end_in;
  wire logic [BKT_N-1:0] rx_bkt = bucket_of(rx_len_in);
  wire logic [BKT_N-1:0] tx_bkt = bucket_of(tx_len_in);
  wire logic rx_short = rx_len_in < LEN_64;
  wire logic rx_long = rx_len_in > LEN_1518;
  wire logic rx_in_range = !rx_short && !rx_long;
  wire logic rx_any_err = rx_fcs_bad_in || rx_other_err_in || rx_short || rx_long;
  wire logic rx_ok = !rx_any_err;
  wire logic hit_good = rx_ev && rx_ok;
  wire logic hit_uni = hit_good && (rx_addr_kind_in == ADDR_UNICAST);
  wire logic hit_multi = rx_ev && (rx_addr_kind_in == ADDR_MULTICAST);
  wire logic hit_bcast = rx_ev && (rx_addr_kind_in == ADDR_BROADCAST);
  wire logic hit_mac_err = rx_ev && rx_any_err;
  wire logic hit_jabber = rx_ev && rx_long && rx_fcs_bad_in;
  wire logic hit_under = rx_ev && rx_short;
  wire logic hit_align = rx_ev && rx_in_range && rx_fcs_bad_in && rx_dribble_in;
  wire logic hit_fcs = rx_ev && rx_in_range && rx_fcs_bad_in && !rx_dribble_in;
  wire logic hit_pause = rx_ev && rx_pause_in && !half_duplex_in;
  wire logic [OCT_W-1:0] rx_oct_add = rx_ev ? {{(OCT_W-LEN_W){1'b0}}, rx_len_in} : '0;
  wire logic [OCT_W-1:0] tx_oct_add = tx_ev ? {{(OCT_W-LEN_W){1'b0}}, tx_len_in} : '0;

  // Counters wrap silently; software that reads them must allow for rollover.
  logic [OCT_W-1:0] rx_oct_q;
  logic [OCT_W-1:0] tx_oct_q;
  logic [CNT_W-1:0] rx_bkt_q [BKT_N];
  logic [CNT_W-1:0] tx_bkt_q [BKT_N];
  logic [CNT_W-1:0] good_q;
  logic [CNT_W-1:0] uni_q;
  logic [CNT_W-1:0] multi_q;
  logic [CNT_W-1:0] bcast_q;
  logic [CNT_W-1:0] mac_err_q;
  logic [CNT_W-1:0] jabber_q;
  logic [CNT_W-1:0] under_q;
  logic [CNT_W-1:0] align_q;
  logic [CNT_W-1:0] fcs_q;
  logic [CNT_W-1:0] pause_q;

  // Next values; every hit term already carries the clock enable.
  wire logic [OCT_W-1:0] rx_oct_d = rx_oct_q + rx_oct_add;
  wire logic [OCT_W-1:0] tx_oct_d = tx_oct_q + tx_oct_add;

  wire logic [CNT_W-1:0] good_d = bump(good_q, hit_good);
  wire logic [CNT_W-1:0] uni_d = bump(uni_q, hit_uni);
  wire logic [CNT_W-1:0] multi_d = bump(multi_q, hit_multi);
  wire logic [CNT_W-1:0] bcast_d = bump(bcast_q, hit_bcast);
  wire logic [CNT_W-1:0] mac_err_d = bump(mac_err_q, hit_mac_err);
  wire logic [CNT_W-1:0] jabber_d = bump(jabber_q, hit_jabber);
  wire logic [CNT_W-1:0] under_d = bump(under_q, hit_under);
  wire logic [CNT_W-1:0] align_d = bump(align_q, hit_align);
  wire logic [CNT_W-1:0] fcs_d = bump(fcs_q, hit_fcs);
  wire logic [CNT_W-1:0] pause_d = bump(pause_q, hit_pause);

  // Octet totals run wider than frame counts because they grow far faster.
  // A pulse that arrives while the clock enable is low is lost, by design.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_oct_q <= OCT_RESET;
    end else begin
      if (clk_en_in) begin
        rx_oct_q <= rx_oct_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_oct_q <= OCT_RESET;
    end else begin
      if (clk_en_in) begin
        tx_oct_q <= tx_oct_d;
      end
    end
  end

  for (genvar i = 0; i < BKT_N; i++) begin : g_bkt
    // Receive slots count every length from 64 octets up, those above 1522 octets included.
    wire logic rx_hit = rx_ev && rx_bkt[i];
    // Transmit has no count above 1522 octets, so that slot stays zero.
    wire logic tx_hit = tx_ev && tx_bkt[i] && (i != BKT_OVER);
    wire logic [CNT_W-1:0] rx_bkt_d = bump(rx_bkt_q[i], rx_hit);
    wire logic [CNT_W-1:0] tx_bkt_d = bump(tx_bkt_q[i], tx_hit);

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        rx_bkt_q[i] <= CNT_RESET;
      end else begin
        if (clk_en_in) begin
          rx_bkt_q[i] <= rx_bkt_d;
        end
      end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        tx_bkt_q[i] <= CNT_RESET;
      end else begin
        if (clk_en_in) begin
          tx_bkt_q[i] <= tx_bkt_d;
        end
      end
    end

    assign rx_bucket_out[i*CNT_W +: CNT_W] = rx_bkt_q[i];
    assign tx_bucket_out[i*CNT_W +: CNT_W] = tx_bkt_q[i];
  end

  // One short process per counter keeps each easy to trim or widen alone.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      good_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        good_q <= good_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uni_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        uni_q <= uni_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      multi_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        multi_q <= multi_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bcast_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        bcast_q <= bcast_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mac_err_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        mac_err_q <= mac_err_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      jabber_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        jabber_q <= jabber_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      under_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        under_q <= under_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      align_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        align_q <= align_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fcs_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        fcs_q <= fcs_d;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pause_q <= CNT_RESET;
    end else begin
      if (clk_en_in) begin
        pause_q <= pause_d;
      end
    end
  end

  // Outputs are the counter flops, so observing them never disturbs counting.
  assign rx_octets_out = rx_oct_q;
  assign tx_octets_out = tx_oct_q;
  assign rx_good_out = good_q;
  assign rx_unicast_out = uni_q;
  assign rx_multicast_out = multi_q;
  assign rx_broadcast_out = bcast_q;
  assign rx_mac_err_out = mac_err_q;
  assign rx_jabber_out = jabber_q;
  assign rx_undersize_out = under_q;
  assign rx_align_err_out = align_q;
  assign rx_fcs_err_out = fcs_q;
  assign rx_pause_out = pause_q;
endmodule : port_frame_statistics_counters

// File: test/port_stats_checker.sv
/* Checker for the port statistics counters; assumes it is bound to that block. */
`timescale 1ns/1ps
module port_stats_checker import port_stats_pkg::*; (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic half_duplex_in,
  input wire logic rx_end_in,
  input wire logic [LEN_W-1:0] rx_len_in,
  input wire logic rx_fcs_bad_in,
  input wire logic tx_end_in,
  input wire logic [LEN_W-1:0] tx_len_in,
  input wire logic [OCT_W-1:0] rx_octets_out,
  input wire logic [OCT_W-1:0] tx_octets_out,
  input wire logic [CNT_W-1:0] rx_jabber_out,
  input wire logic [CNT_W-1:0] rx_undersize_out,
  input wire logic [CNT_W-1:0] rx_pause_out
);
  wire e = rx_end_in && clk_en_in;
  wire t = tx_end_in && clk_en_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rxo; e |=> rx_octets_out == $past(rx_octets_out) + $past(rx_len_in); endproperty
  a_rxo: assert property (p_rxo) else $error("rx octets");
  property p_txo; t |=> tx_octets_out == $past(tx_octets_out) + $past(tx_len_in); endproperty
  a_txo: assert property (p_txo) else $error("tx octets");
  property p_rxi; !e |=> $stable(rx_octets_out); endproperty
  a_rxi: assert property (p_rxi) else $error("rx idle");
  property p_txi; !t |=> $stable(tx_octets_out); endproperty
  a_txi: assert property (p_txi) else $error("tx idle");
  property p_und; e && rx_len_in < LEN_64 |=> rx_undersize_out == $past(rx_undersize_out) + 1;
  endproperty
  a_und: assert property (p_und) else $error("undersize");
  property p_unn; e && rx_len_in >= LEN_64 |=> $stable(rx_undersize_out); endproperty
  a_unn: assert property (p_unn) else $error("undersize extra");
  property p_jab; e && rx_fcs_bad_in && rx_len_in > LEN_1518 |=> $changed(rx_jabber_out);
  endproperty
  a_jab: assert property (p_jab) else $error("jabber");
  property p_jbn; e && rx_len_in <= LEN_1518 |=> $stable(rx_jabber_out); endproperty
  a_jbn: assert property (p_jbn) else $error("jabber extra");
  property p_hdx; e && half_duplex_in |=> $stable(rx_pause_out); endproperty
  a_hdx: assert property (p_hdx) else $error("pause half");
  cover property (e && rx_fcs_bad_in);
  cover property (t);
  cover property (e && half_duplex_in);
endmodule : port_stats_checker
bind port_frame_statistics_counters port_stats_checker u_chk (.*);

// File: test/mac_status_model.sv
/* Port MAC status reporter; assumes the bench calls its task after reset. */
`timescale 1ns/1ps
module mac_status_model import port_stats_pkg::*; (
  input wire logic clk_in,
  output logic rx_end_out,
  output logic [LEN_W-1:0] rx_len_out,
  output addr_kind_t kind_out,
  output logic [3:0] flags_out,
  output logic tx_end_out,
  output logic [LEN_W-1:0] tx_len_out
);
  initial {rx_end_out, rx_len_out, flags_out, tx_end_out, tx_len_out} = '0;
  initial kind_out = ADDR_UNICAST;
  // Status lines flip to junk after the pulse so a stale value never helps.
  task automatic rx(input logic [LEN_W-1:0] l, input addr_kind_t k, input logic [3:0] f);
    @(posedge clk_in);
    {rx_end_out, rx_len_out, flags_out, tx_end_out, tx_len_out} <= {1'b1, l, f, 1'b1, l};
    kind_out <= k;
    @(posedge clk_in);
    {rx_end_out, rx_len_out, flags_out, tx_end_out, tx_len_out} <= {1'b0, ~l, ~f, 1'b0, ~l};
    kind_out <= addr_kind_t'(~k);
  endtask : rx
endmodule : mac_status_model

// File: test/port_frame_statistics_counters_tb.sv
/* Bench for the port statistics counters; assumes the checker binds itself. */
`timescale 1ns/1ps
module port_frame_statistics_counters_tb import port_stats_pkg::*;;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1, half_duplex_in = 1'b0;
  logic rx_end_in, tx_end_in;
  logic [3:0] fl;
  logic [LEN_W-1:0] rx_len_in, tx_len_in;
  addr_kind_t rx_addr_kind_in;
  logic [OCT_W-1:0] rx_octets_out, tx_octets_out;
  logic [BKT_N*CNT_W-1:0] rx_bucket_out, tx_bucket_out;
  logic [CNT_W-1:0] rx_good_out, rx_unicast_out, rx_multicast_out, rx_broadcast_out;
  logic [CNT_W-1:0] rx_mac_err_out, rx_jabber_out, rx_undersize_out, rx_align_err_out;
  logic [CNT_W-1:0] rx_fcs_err_out, rx_pause_out;
  wire rx_fcs_bad_in = fl[3], rx_dribble_in = fl[2];
  wire rx_other_err_in = fl[1], rx_pause_in = fl[0];
  wire [10*CNT_W-1:0] cs = {rx_pause_out, rx_fcs_err_out, rx_align_err_out, rx_undersize_out,
    rx_jabber_out, rx_mac_err_out, rx_broadcast_out, rx_multicast_out, rx_unicast_out, rx_good_out};
  int err_count = 0, check_count = 0;
  int ls[15] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519, 1522, 1523};
  port_frame_statistics_counters uut (.*);
  mac_status_model mac (.clk_in(core_clk_in), .rx_end_out(rx_end_in), .rx_len_out(rx_len_in),
    .kind_out(rx_addr_kind_in), .flags_out(fl), .tx_end_out(tx_end_in), .tx_len_out(tx_len_in));
  always #2 core_clk_in = ~core_clk_in;
  task automatic chk(input string n, input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic int bk(input int l);
    return l < 64 ? 8 : l == 64 ? 0 : l <= 127 ? 1 : l <= 255 ? 2 : l <= 511 ? 3 :
      l <= 1023 ? 4 : l <= 1518 ? 5 : l <= 1522 ? 6 : 7;
  endfunction : bk
  // One frame both ways; m marks which of the ten rx counters must step.
  task automatic fr(input int l, input addr_kind_t k, input logic [3:0] f, v, input logic [9:0] m);
    logic [10*CNT_W-1:0] c0;
    logic [BKT_N*CNT_W-1:0] r0, t0;
    logic [OCT_W-1:0] o0, p0;
    {c0, r0, t0, o0, p0} = {cs, rx_bucket_out, tx_bucket_out, rx_octets_out, tx_octets_out};
    mac.rx(l[LEN_W-1:0], k, f);
    #1;
    chk("rx octets", rx_octets_out, o0 + (v ? l : 0));
    chk("tx octets", tx_octets_out, p0 + (v ? l : 0));
    for (int i = 0; i < BKT_N; i++) begin
      chk($sformatf("rx bucket %0d", i), rx_bucket_out[i*CNT_W+:CNT_W],
        r0[i*CNT_W+:CNT_W] + (v && i == bk(l)));
      chk($sformatf("tx bucket %0d", i), tx_bucket_out[i*CNT_W+:CNT_W],
        t0[i*CNT_W+:CNT_W] + (v && i == bk(l) && i < 7));
    end
    for (int i = 0; i < 10; i++) begin
      chk($sformatf("counter %0d", i), cs[i*CNT_W+:CNT_W],
        c0[i*CNT_W+:CNT_W] + m[i]);
    end
  endtask : fr
  task automatic t_sizes;
    foreach (ls[j]) begin
      fr(ls[j], ADDR_UNICAST, 4'h0, 1'b1,
        ls[j] < 64 ? 10'h050 : ls[j] > 1518 ? 10'h010 : 10'h003);
    end
  endtask : t_sizes
  task automatic t_errors;
    fr(100, ADDR_MULTICAST, 4'h8, 1'b1, 10'h114);
    fr(200, ADDR_BROADCAST, 4'hc, 1'b1, 10'h098);
    fr(1536, ADDR_UNICAST, 4'hc, 1'b1, 10'h030);
    fr(64, ADDR_UNICAST, 4'h2, 1'b1, 10'h010);
    fr(64, ADDR_BROADCAST, 4'h0, 1'b1, 10'h009);
  endtask : t_errors
  task automatic t_pause;
    fr(64, ADDR_MULTICAST, 4'h1, 1'b1, 10'h205);
    @(posedge core_clk_in) half_duplex_in <= 1'b1;
    fr(64, ADDR_MULTICAST, 4'h1, 1'b1, 10'h005);
    @(posedge core_clk_in) clk_en_in <= 1'b0;
    fr(64, ADDR_UNICAST, 4'h1, 1'b0, 10'h000);
    @(posedge core_clk_in) clk_en_in <= 1'b1;
  endtask : t_pause
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge core_clk_in);
    for (int i = 0; i < 10; i++) begin
      chk($sformatf("reset counter %0d", i), cs[i*CNT_W+:CNT_W], '0);
    end
    for (int i = 0; i < BKT_N; i++) begin
      chk($sformatf("reset rx bucket %0d", i), rx_bucket_out[i*CNT_W+:CNT_W], '0);
      chk($sformatf("reset tx bucket %0d", i), tx_bucket_out[i*CNT_W+:CNT_W], '0);
    end
    chk("reset rx octets", rx_octets_out, '0);
    chk("reset tx octets", tx_octets_out, '0);
    rst_n_in <= 1'b1;
    t_sizes;
    t_errors;
    t_pause;
    give_verdict;
  end
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
endmodule : port_frame_statistics_counters_tb
